/* File: dcc_pkg.sv */
// Package of register map, field layout, reset values and divider limits for the dual codec block.
package dcc_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] DCC_A_PWR0 = 4'h0;
  localparam logic [3:0] DCC_A_PWR1 = 4'h1;
  localparam logic [3:0] DCC_A_MIX0 = 4'h2;
  localparam logic [3:0] DCC_A_MIX1 = 4'h3;
  localparam logic [3:0] DCC_A_OSC0 = 4'h4;
  localparam logic [3:0] DCC_A_OSC1 = 4'h5;
  localparam logic [3:0] DCC_A_SMP0 = 4'h6;
  localparam logic [3:0] DCC_A_SMP1 = 4'h7;
  localparam logic [3:0] DCC_A_GLB = 4'h8;
  localparam logic [3:0] DCC_A_TST = 4'h9;
  localparam logic [3:0] DCC_A_RSV6 = 4'hA;
  localparam logic [3:0] DCC_A_RSV7 = 4'hB;
  localparam logic [3:0] DCC_A_LOCK = 4'hF;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DCC_B_RSVA = 6;
  localparam int DCC_B_RLOOP = 5;
  localparam int DCC_B_DIGITAL_LOOPBACK = 4;
  localparam int DCC_B_CODEC_POWER_DOWN = 3;
  localparam int DCC_B_CLR = 2;
  localparam int DCC_B_LINE_DRIVER_ENABLE = 1;
  localparam int DCC_B_LLOOP = 0;
  localparam int DCC_B_MSEL = 6;
  localparam int DCC_B_SWRST = 4;
  localparam int DCC_B_SSEL = 2;
  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [6:0] DCC_R_PWR = 7'h0C;
  localparam logic [6:0] DCC_R_MIX = 7'h00;
  localparam logic [5:0] DCC_R_OSDIV = 6'h10;
  localparam logic [5:0] DCC_MIN_OSDIV = 6'h07;
  localparam logic [6:0] DCC_R_SCDIV = 7'h33;
  localparam logic [6:0] DCC_MIN_SCDIV = 7'h33;
  localparam logic [1:0] DCC_R_SYSDIV = 2'h2;
  localparam logic [7:0] DCC_LOCK_VAL = 8'h55;
  localparam int DCC_XTAL_PER_SYS = 7;
  localparam int DCC_XTAL_PER_MCLK = 8;
endpackage

/* File: dcc_if.sv */
// Interface joining the host controller to the dual codec register bank.
`timescale 1ns/1ps
interface dcc_if;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

/* File: dcc_device.sv */
// Dual codec register bank with clock dividers and per-codec control outputs.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module dcc_device
  import dcc_pkg::*;
(
  input wire logic clk_in, // crystal-derived clock
  input wire logic sys_rst_in, // async reset, active high
  dcc_if.dev bus, // register port
  input wire logic [1:0] mclk_in, // codec master clocks, synchronous
  output logic [1:0] osr_tick_out, // oversampling clock enable per codec
  output logic [1:0] fs_tick_out, // sample clock enable per codec
  output logic sys_tick_out, // system clock enable
  output logic [1:0] remote_loop_out, // remote analog loopback
  output logic [1:0] digital_loop_out, // digital loopback
  output logic [1:0] clear_out, // datapath clear
  output logic [1:0] power_down_out, // codec power down
  output logic [1:0] line_drv_en_out, // line driver enable
  output logic [1:0] local_loop_out // local analog loopback
);
  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [6:0] pwr [2];
  logic [6:0] mix [2];
  logic [5:0] osdiv [2];
  logic [1:0] msel;
  logic [6:0] scdiv [2];
  logic [1:0] sysdiv;
  logic ssel;
  logic [2:0] tstw;
  logic swrst;
  logic rst_all;
  logic [1:0] mclk_q;
  assign rst_all = sys_rst_in | swrst;

  // Software reset pulses one cycle and then clears itself.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      swrst <= 1'b0;
    end else begin
      swrst <= bus.wr && bus.addr == DCC_A_GLB && bus.wdata[DCC_B_SWRST];
    end
  end

  // Global registers exist once and are reached through the one register port.
  always_ff @(posedge clk_in or posedge rst_all) begin
    if (rst_all) begin
      sysdiv <= DCC_R_SYSDIV;
      ssel <= 1'b0;
      tstw <= 3'h0;
    end else if (bus.wr && bus.addr == DCC_A_GLB) begin
      sysdiv <= bus.wdata[1:0];
      ssel <= bus.wdata[DCC_B_SSEL];
    end else if (bus.wr && bus.addr == DCC_A_TST) begin
      tstw <= bus.wdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Per-codec registers and clock dividers
  // ----------------------------------------------------------------
  generate
    for (genvar c = 0; c < 2; c++) begin : g_codec
      logic [5:0] os_cnt;
      logic [7:0] fs_cnt;
      logic osr_en;
      logic [7:0] fs_top;
      always_ff @(posedge clk_in or posedge rst_all) begin
        if (rst_all) begin
          pwr[c] <= DCC_R_PWR;
          mix[c] <= DCC_R_MIX;
          osdiv[c] <= DCC_R_OSDIV;
          msel[c] <= 1'b0;
          scdiv[c] <= DCC_R_SCDIV;
        end else if (bus.wr) begin
          if (bus.addr == DCC_A_PWR0 + 4'(c)) begin
            pwr[c] <= bus.wdata[6:0];
          end
          if (bus.addr == DCC_A_MIX0 + 4'(c)) begin
            mix[c] <= bus.wdata[6:0];
          end
          if (bus.addr == DCC_A_OSC0 + 4'(c)) begin
            osdiv[c] <= bus.wdata[5:0];
            msel[c] <= bus.wdata[DCC_B_MSEL];
          end
          if (bus.addr == DCC_A_SMP0 + 4'(c)) begin
            scdiv[c] <= (bus.wdata[6:0] < DCC_MIN_SCDIV) ? DCC_MIN_SCDIV
                        : bus.wdata[6:0];
          end
        end
      end
      // Oversampling tick: crystal divided by the divider, or the master clock.
      assign osr_en = msel[c] ? (mclk_in[c] & ~mclk_q[c]) : (os_cnt == 6'h00);
      always_ff @(posedge clk_in or posedge rst_all) begin
        if (rst_all) begin
          os_cnt <= 6'h00;
        end else if (os_cnt == 6'h00) begin
          os_cnt <= osdiv[c] - 6'h01;
        end else begin
          os_cnt <= os_cnt - 6'h01;
        end
      end
      // Sample tick spans twice the divider count of oversampling ticks.
      assign fs_top = {scdiv[c], 1'b0} - 8'h01;
      always_ff @(posedge clk_in or posedge rst_all) begin
        if (rst_all) begin
          fs_cnt <= 8'h00;
          osr_tick_out[c] <= 1'b0;
          fs_tick_out[c] <= 1'b0;
        end else begin
          osr_tick_out[c] <= osr_en && !pwr[c][DCC_B_CODEC_POWER_DOWN];
          fs_tick_out[c] <= osr_en && !pwr[c][DCC_B_CODEC_POWER_DOWN] && fs_cnt == 8'h00;
          if (osr_en) begin
            fs_cnt <= (fs_cnt == 8'h00) ? fs_top : fs_cnt - 8'h01;
          end
        end
      end
      always_ff @(posedge clk_in or posedge rst_all) begin
        if (rst_all) begin
          remote_loop_out[c] <= 1'b0;
          digital_loop_out[c] <= 1'b0;
          clear_out[c] <= 1'b1;
          power_down_out[c] <= 1'b1;
          line_drv_en_out[c] <= 1'b0;
          local_loop_out[c] <= 1'b0;
        end else begin
          remote_loop_out[c] <= pwr[c][DCC_B_RLOOP];
          digital_loop_out[c] <= pwr[c][DCC_B_DIGITAL_LOOPBACK];
          clear_out[c] <= pwr[c][DCC_B_CLR];
          power_down_out[c] <= pwr[c][DCC_B_CODEC_POWER_DOWN];
          line_drv_en_out[c] <= pwr[c][DCC_B_LINE_DRIVER_ENABLE];
          local_loop_out[c] <= pwr[c][DCC_B_LLOOP];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mclk_q <= 2'b00;
    end else begin
      mclk_q <= mclk_in;
    end
  end

  // ----------------------------------------------------------------
  // System clock divider: ratios 1, 3/2, 2 and 3
  // ----------------------------------------------------------------
  logic [2:0] sys_ph;
  logic sys_hit;
  always_comb begin
    case (sysdiv)
      2'h0: sys_hit = 1'b1;
      2'h1: sys_hit = (sys_ph != 3'h2) && (sys_ph != 3'h5);
      2'h2: sys_hit = sys_ph[0];
      2'h3: sys_hit = (sys_ph == 3'h2) || (sys_ph == 3'h5);
      default: sys_hit = 1'b0;
    endcase
  end
  always_ff @(posedge clk_in or posedge rst_all) begin
    if (rst_all) begin
      sys_ph <= 3'h0;
      sys_tick_out <= 1'b0;
    end else begin
      sys_ph <= (sys_ph == 3'h5) ? 3'h0 : sys_ph + 3'h1;
      sys_tick_out <= sys_hit;
    end
  end

  // ----------------------------------------------------------------
  // Read port: data one cycle after the strobe, bit 7 always zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus.rdata <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        DCC_A_PWR0: bus.rdata <= {1'b0, pwr[0]};
        DCC_A_PWR1: bus.rdata <= {1'b0, pwr[1]};
        DCC_A_MIX0: bus.rdata <= {1'b0, mix[0]};
        DCC_A_MIX1: bus.rdata <= {1'b0, mix[1]};
        DCC_A_OSC0: bus.rdata <= {1'b0, msel[0], osdiv[0]};
        DCC_A_OSC1: bus.rdata <= {1'b0, msel[1], osdiv[1]};
        DCC_A_SMP0: bus.rdata <= {1'b0, scdiv[0]};
        DCC_A_SMP1: bus.rdata <= {1'b0, scdiv[1]};
        DCC_A_GLB: bus.rdata <= {5'h00, ssel, sysdiv};
        DCC_A_TST: bus.rdata <= {5'h00, tstw};
        DCC_A_LOCK: bus.rdata <= DCC_LOCK_VAL;
        default: bus.rdata <= 8'h00;
      endcase
    end else begin
      bus.rdata <= 8'h00;
    end
  end
endmodule

/* File: dcc_host.sv */
// Host controller that issues register reads and writes to the dual codec.
`timescale 1ns/1ps
module dcc_host
  import dcc_pkg::*;
(
  input wire logic clk_in, // system clock
  input wire logic sys_rst_in, // async reset, active high
  dcc_if.host bus, // device register port
  input wire logic cmd_valid_in, // command request pulse
  input wire logic cmd_write_in, // 1 write, 0 read
  input wire logic [3:0] cmd_addr_in, // register address
  input wire logic [7:0] cmd_data_in, // write data
  output logic busy_out, // command in flight
  output logic done_out, // command finished pulse
  output logic [7:0] rdata_out // read data captured at command end, zero after a write
);
  typedef enum logic [1:0] {DCC_IDLE, DCC_WAIT} dcc_state_e;
  dcc_state_e state;
  logic [7:0] wval;

  // Writes clear bit 7 and the reserved analog bit, and keep the oversample divider legal.
  // The sample divider passes unchanged, since the device clamps it itself.
  always_comb begin
    wval = {1'b0, cmd_data_in[6:0]};
    if (cmd_addr_in == DCC_A_PWR0 || cmd_addr_in == DCC_A_PWR1) begin
      wval[DCC_B_RSVA] = 1'b0;
    end
    if ((cmd_addr_in == DCC_A_OSC0 || cmd_addr_in == DCC_A_OSC1) &&
        cmd_data_in[5:0] < DCC_MIN_OSDIV) begin
      wval[5:0] = DCC_MIN_OSDIV;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= DCC_IDLE;
      bus.addr <= 4'h0;
      bus.wdata <= 8'h00;
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      rdata_out <= 8'h00;
    end else begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      done_out <= 1'b0;
      case (state)
        DCC_IDLE: begin
          if (cmd_valid_in) begin
            bus.addr <= cmd_addr_in;
            bus.wdata <= wval;
            bus.wr <= cmd_write_in;
            bus.rd <= !cmd_write_in;
            busy_out <= 1'b1;
            state <= DCC_WAIT;
          end
        end
        DCC_WAIT: begin
          if (!bus.wr && !bus.rd) begin
            rdata_out <= bus.rdata;
            busy_out <= 1'b0;
            done_out <= 1'b1;
            state <= DCC_IDLE;
          end
        end
        default: state <= DCC_IDLE;
      endcase
    end
  end
endmodule

/* File: dcc_checker.sv */
// Checker of the register port between the dual codec host and device.
`timescale 1ns/1ps
module dcc_checker
  import dcc_pkg::*;
(
  input wire logic clk_in, // clock
  input wire logic sys_rst_in, // async reset, active high
  input wire logic [3:0] addr, // register address
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic [7:0] rdata // read data
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // ----------------------------------------------------------------
  // Read answers
  // ----------------------------------------------------------------
  sequence s_rd(logic [3:0] a);
    rd && addr == a;
  endsequence
  property p_bit7;
    rd |=> !rdata[7];
  endproperty
  a_bit7: assert property (p_bit7) else $error("read data bit 7 set");
  property p_idle;
    !rd |=> rdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside answer");
  property p_smp_min;
    rd && (addr == DCC_A_SMP0 || addr == DCC_A_SMP1) |=> rdata[6:0] >= 7'h33;
  endproperty
  a_smp_min: assert property (p_smp_min) else $error("sample divider low");
  property p_swrst;
    s_rd(DCC_A_GLB) |=> rdata[7:3] == 5'h00;
  endproperty
  a_swrst: assert property (p_swrst) else $error("reset bit reads one");
  property p_unmapped;
    rd && addr inside {4'hC, 4'hD, 4'hE} |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  property p_pwr0_hold;
    logic [7:0] v;
    (wr && addr == DCC_A_PWR0, v = wdata) ##[3:5] s_rd(DCC_A_PWR0) |=> rdata == {1'b0, v[6:0]};
  endproperty
  a_pwr0_hold: assert property (p_pwr0_hold) else $error("power 0 lost");
  property p_pwr1_hold;
    logic [7:0] v;
    (wr && addr == DCC_A_PWR1, v = wdata) ##[3:5] s_rd(DCC_A_PWR1) |=> rdata == {1'b0, v[6:0]};
  endproperty
  a_pwr1_hold: assert property (p_pwr1_hold) else $error("power 1 lost");
  property p_osc0_hold;
    logic [7:0] v;
    (wr && addr == DCC_A_OSC0, v = wdata) ##[3:5] s_rd(DCC_A_OSC0) |=> rdata == {1'b0, v[6:0]};
  endproperty
  a_osc0_hold: assert property (p_osc0_hold) else $error("oversample lost");
  property p_smp0_clamp;
    logic [7:0] v;
    (wr && addr == DCC_A_SMP0, v = wdata) ##[3:5] s_rd(DCC_A_SMP0)
      |=> rdata == {1'b0, (v[6:0] < 7'h33) ? 7'h33 : v[6:0]};
  endproperty
  a_smp0_clamp: assert property (p_smp0_clamp) else $error("sample clamp");
endmodule

/* File: dcc_tb_top.sv */
// Testbench of the dual codec host and device pair.
`timescale 1ns/1ps
module dcc_tb_top
  import dcc_pkg::*;
;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [1:0] mclk_in = 2'b00;
  logic cv = 1'b0;
  logic cw = 1'b0;
  logic [3:0] ca = 4'h0;
  logic [7:0] cd = 8'h00;
  logic busy, done, sys;
  logic [7:0] rdo;
  logic [1:0] oversampling_ratio, fs, rl, dl, cl, pd, le, ll;
  logic [31:0] seed = 32'hCB497A84;
  logic [11:0] cor [9] = '{12'h600, 12'h632, 12'h77F, 12'h407, 12'h53F, 12'hF00, 12'hA5A,
    12'h9FD, 12'h403};
  int sys_cnt [4] = '{12, 8, 6, 4};
  int errors = 0;
  int total_checks = 0;
  int mc = 0;
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    mc <= mc + 1;
    if (mc % 4 == 3) mclk_in[0] <= ~mclk_in[0];
    if (mc % 6 == 5) mclk_in[1] <= ~mclk_in[1];
  end
  dcc_if i_dcc_if ();
  dcc_device i_dcc_device (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus(i_dcc_if.dev),
    .mclk_in(mclk_in), .osr_tick_out(oversampling_ratio), .fs_tick_out(fs), .sys_tick_out(sys),
    .remote_loop_out(rl), .digital_loop_out(dl), .clear_out(cl), .power_down_out(pd),
    .line_drv_en_out(le), .local_loop_out(ll));
  dcc_host i_dcc_host (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus(i_dcc_if.host),
    .cmd_valid_in(cv), .cmd_write_in(cw), .cmd_addr_in(ca), .cmd_data_in(cd),
    .busy_out(busy), .done_out(done), .rdata_out(rdo));
  dcc_checker i_dcc_checker (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr(i_dcc_if.addr),
    .wdata(i_dcc_if.wdata), .wr(i_dcc_if.wr), .rd(i_dcc_if.rd), .rdata(i_dcc_if.rdata));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] rstv(logic [3:0] a);
    case (a)
      4'h0, 4'h1: return 8'h0C;
      4'h4, 4'h5: return 8'h10;
      4'h6, 4'h7: return 8'h33;
      4'h8: return 8'h02;
      4'hF: return 8'h55;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] expv(logic [3:0] a, logic [7:0] d);
    case (a)
      4'h0, 4'h1: return {2'b00, d[5:0]};
      4'h4, 4'h5: return {1'b0, d[6], (d[5:0] < 6'h07) ? 6'h07 : d[5:0]};
      4'h6, 4'h7: return (d[6:0] < 7'h33) ? 8'h33 : {1'b0, d[6:0]};
      4'h9: return {5'h00, d[2:0]};
      4'hA: return 8'h00;
      4'hF: return 8'h55;
      default: return {1'b0, d[6:0]};
    endcase
  endfunction
  function automatic logic [5:0] outs(int i);
    return {rl[i], dl[i], cl[i], pd[i], le[i], ll[i]};
  endfunction
  function automatic logic tk(int w);
    return (w == 0) ? oversampling_ratio[0] : (w == 1) ? fs[0] : (w == 2) ? oversampling_ratio[1] : fs[1];
  endfunction
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      errors++;
    end
  endtask
  task automatic step();
    @(posedge clk_in);
    #1;
  endtask
  task automatic cmd(logic w, logic [3:0] a, logic [7:0] d);
    @(posedge clk_in);
    cv <= 1'b1;
    cw <= w;
    ca <= a;
    cd <= d;
    @(posedge clk_in);
    cv <= 1'b0;
    #1;
    chk(16'(busy), 16'h0001);
    for (int k = 0; k < 12 && done !== 1'b1; k++) step();
    chk(16'(done), 16'h0001);
  endtask
  task automatic gap(int w, output int n);
    repeat (8000) begin
      if (tk(w) === 1'b1) break;
      step();
    end
    step();
    n = 1;
    repeat (8000) begin
      if (tk(w) === 1'b1) break;
      step();
      n++;
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #500000;
    errors++;
    results();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    int n;
    logic [3:0] a;
    logic [7:0] d;
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      cmd(0, 4'(i), 8'h00);
      chk(16'(rdo), 16'(rstv(4'(i))));
    end
    for (int i = 0; i < 2; i++) begin
      chk(16'(outs(i)), 16'h000C);
    end
    $display("test reset values done");
    for (int i = 0; i < 40; i++) begin
      a = (i < 9) ? cor[i][11:8] : 4'(rnd() % 8);
      d = (i < 9) ? cor[i][7:0] : 8'(rnd());
      cmd(1, a, d);
      cmd(0, a, 8'h00);
      chk(16'(rdo), 16'(expv(a, d)));
      if (a < 2) begin
        chk(16'(outs(a) >> 3), 16'({d[5:4], d[2]}));
        chk(16'(outs(a) & 6'h07), 16'({d[3], d[1:0]}));
      end
    end
    $display("test register writes done");
    for (int k = 0; k < 4; k++) begin
      d = {5'h00, 1'(k % 2), 2'(k)};
      cmd(1, 4'h8, d);
      cmd(0, 4'h8, 8'h00);
      chk(16'(rdo), 16'(d));
      repeat (4) step();
      n = 0;
      repeat (12) begin
        step();
        if (sys === 1'b1) n++;
      end
      chk(16'(n), 16'(sys_cnt[k]));
    end
    $display("test system divider done");
    d = 8'(7 + rnd() % 16);
    cmd(1, 4'h0, 8'h00);
    cmd(1, 4'h1, 8'h00);
    cmd(1, 4'h4, d);
    cmd(1, 4'h6, 8'h33);
    cmd(1, 4'h5, 8'h47);
    cmd(1, 4'h7, 8'h33);
    gap(0, n);
    chk(16'(n), 16'(d));
    gap(1, n);
    chk(16'(n), 16'(d) * 16'h0066);
    gap(2, n);
    chk(16'(n), 16'h000C);
    gap(3, n);
    chk(16'(n), 16'h04C8);
    $display("test clock dividers done");
    cmd(1, 4'h8, 8'h10);
    repeat (2) step();
    cmd(0, 4'h0, 8'h00);
    chk(16'(rdo), 16'h000C);
    cmd(0, 4'h8, 8'h00);
    chk(16'(rdo), 16'h0002);
    cmd(1, 4'h1, 8'h3F);
    sys_rst_in <= 1'b1;
    repeat (2) step();
    sys_rst_in <= 1'b0;
    cmd(0, 4'h1, 8'h00);
    chk(16'(rdo), 16'h000C);
    n = 0;
    repeat (40) begin
      step();
      if (oversampling_ratio !== 2'b00) n++;
    end
    chk(16'(n), 16'h0000);
    $display("test resets done");
    results();
  end
endmodule
